// >>> adsc_control.sv
// module: converter control, sequencer and register slave of the 10-bit converter
// What this block does
// RULE1 - three select bits pick conversion clock source
// RULE2 - channel field routes one of eight inputs
// RULE3 - software avoids unimplemented channel codes
// RULE4 - start bit launches, reads busy, self-clears
// RULE5 - power bit enables converter, off stops it
// RULE6 - unimplemented control bits read as zero
// RULE7 - justify bit selects result byte layout
// RULE8 - port code marks pins analog or digital
// RULE9 - port code selects reference sources
// RULE10 - reset forces shared pins to analog
// RULE11 - sleep conversions only on internal clock
// RULE12 - successive approximation yields ten-bit result
// RULE13 - reset clears registers, aborts any conversion
// RULE14 - completion loads result, clears start, flags
// RULE15 - four converter registers on the bus
// RULE16 - conversion lasts twelve bit periods
// RULE17 - software waits two periods between conversions
// RULE18 - result registers keep content over reset
// RULE19 - flag sticks until cleared, gated interrupt
`timescale 1ns/1ps

module adsc_control
  import adsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // clock and power environment
  input  wire logic        rcTick,
  input  wire logic        sleepMode,
  // conversion core
  input  wire logic        compIn,
  output logic      [9:0]  sarTrial,
  output logic             sampleHold,
  output logic             powerOn,
  output logic      [2:0]  chanSel,
  // pin functions
  output logic      [7:0]  analogPinMask,
  output logic             vrefPosExt,
  output logic             vrefNegExt,
  // interrupt
  output logic             irq
);

  // ****************************************
  // state and helpers
  // ****************************************
  adsc_regs_t r_q;       // registered state
  adsc_regs_t r_d;       // next state
  logic [2:0] clkSel;    // full clock select
  logic       useRc;     // internal rc clock chosen
  logic       divHit;    // divider at its last count
  logic       tadTick;   // one bit period elapsed
  logic       busAct;    // access phase in progress
  logic       busDone;   // completing edge of access
  logic       startHit;  // conversion launched
  logic       doneHit;   // conversion finished
  logic [32:0] rdWord;   // hit flag and read data
  logic [3:0] bitIdx;    // result bit decided this period

  // ****************************************
  // divider last count per clock select
  // ****************************************
  function automatic logic [5:0] divLast(input logic [2:0] s);
    unique case (s)
      3'h0:    divLast = 6'h01; // osc/2
      3'h4:    divLast = 6'h03; // osc/4
      3'h1:    divLast = 6'h07; // osc/8
      3'h5:    divLast = 6'h0f; // osc/16
      3'h2:    divLast = 6'h1f; // osc/32
      3'h6:    divLast = 6'h3f; // osc/64
      default: divLast = 6'h3f; // rc codes, divider idle
    endcase
  endfunction

  // ****************************************
  // pin map: {analog mask, vref+ pin, vref- pin}
  // ****************************************
  // vref pins are counted as analog: never digital
  function automatic logic [9:0] pinMap(input logic [3:0] c);
    unique case (c)
      4'h0: pinMap = {8'hff, 1'b0, 1'b0};
      4'h1: pinMap = {8'hff, 1'b1, 1'b0};
      4'h2: pinMap = {8'h1f, 1'b0, 1'b0};
      4'h3: pinMap = {8'h1f, 1'b1, 1'b0};
      4'h4: pinMap = {8'h0b, 1'b0, 1'b0};
      4'h5: pinMap = {8'h0b, 1'b1, 1'b0};
      4'h6: pinMap = {8'h00, 1'b0, 1'b0};
      4'h7: pinMap = {8'h00, 1'b0, 1'b0};
      4'h8: pinMap = {8'hff, 1'b1, 1'b1};
      4'h9: pinMap = {8'h3f, 1'b0, 1'b0};
      4'ha: pinMap = {8'h3f, 1'b1, 1'b0};
      4'hb: pinMap = {8'h3f, 1'b1, 1'b1};
      4'hc: pinMap = {8'h1f, 1'b1, 1'b1};
      4'hd: pinMap = {8'h0f, 1'b1, 1'b1};
      4'he: pinMap = {8'h01, 1'b0, 1'b0};
      4'hf: pinMap = {8'h0d, 1'b1, 1'b1};
    endcase
  endfunction

  // ****************************************
  // clock select and bit-period ticks
  // ****************************************
  // RULE1 - select the clock
  assign clkSel = {r_q.clkSelHi, r_q.clkSelLo};
  assign useRc  = clkSel[1] & clkSel[0];
  assign divHit = (r_q.divCnt == divLast(clkSel));
  // RULE11 - sleep stalls osc clock
  // the osc divider stops in sleep; only the rc tick keeps running
  assign tadTick = (r_q.st == ADSC_CONV) &&
                   (useRc ? rcTick : (!sleepMode && divHit));
  // periods 1..10 decide bits 9..0; other periods never index with it
  assign bitIdx  = 4'ha - r_q.tadCnt;
  assign busAct  = psel && penable;
  assign busDone = busAct && r_q.ready;

  // ****************************************
  // read mux
  // ****************************************
  // registers are sampled into prdata at the same edge that raises pready
  always_comb begin
    rdWord = {1'b1, 32'h0};
    unique case (paddr)
      // RULE7 - justify the result
      ADDR_RESH: begin
        if (r_q.just) begin
          rdWord[7:0] = {6'h00, r_q.result[9:8]};
        end else begin
          rdWord[7:0] = r_q.result[9:2];
        end
      end
      ADDR_RESL: begin
        if (r_q.just) begin
          rdWord[7:0] = r_q.result[7:0];
        end else begin
          rdWord[7:0] = {r_q.result[1:0], 6'h00};
        end
      end
      // RULE6 - bit 1 reads zero
      ADDR_CTRL0: begin
        rdWord[7:0] = {r_q.clkSelLo, r_q.chanSel, r_q.go,
                       1'b0, r_q.pwr};
      end
      // RULE6 - bits 5:4 read zero
      ADDR_CTRL1: begin
        rdWord[7:0] = {r_q.just, r_q.clkSelHi, 2'h0, r_q.pcfg};
      end
      ADDR_STAT: begin
        rdWord[IRQ_DONE_BIT] = r_q.flag;
      end
      ADDR_MASK: begin
        rdWord[IRQ_DONE_BIT] = r_q.mask;
      end
      // unmapped: zero data and slave error
      default: begin
        rdWord[32] = 1'b0;
      end
    endcase
  end

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    r_d      = r_q;
    startHit = 1'b0;
    doneHit  = 1'b0;
    r_d.ready = 1'b0;
    r_d.err   = 1'b0;
    // one wait state: capture data and raise pready at the same edge
    if (busAct && !r_q.ready) begin
      r_d.ready = 1'b1;
      r_d.rdata = rdWord[31:0];
      r_d.err   = !rdWord[32];
    end
    // RULE19 - read clears flag
    // the clear goes first so that a completion below wins
    if (busDone && !pwrite && paddr == ADDR_STAT) begin
      r_d.flag = 1'b0;
    end
    // register writes at the completing edge
    if (busDone && pwrite) begin
      unique case (paddr)
        ADDR_CTRL0: begin
          r_d.clkSelLo = pwdata[C0_CLK_LSB +: 2];
          // RULE2 - channel routing field
          r_d.chanSel  = pwdata[C0_CHAN_LSB +: 3];
          r_d.pwr      = pwdata[C0_PWR_BIT];
          // RULE4 - start while powered
          if (pwdata[C0_GO_BIT] && pwdata[C0_PWR_BIT] &&
              r_q.st == ADSC_IDLE) begin
            startHit   = 1'b1;
            r_d.go     = 1'b1;
            r_d.st     = ADSC_CONV;
            r_d.tadCnt = SAMPLE_TAD;
            r_d.divCnt = 6'h00;
          end
        end
        ADDR_CTRL1: begin
          r_d.just     = pwdata[C1_JUST_BIT];
          r_d.clkSelHi = pwdata[C1_CLK2_BIT];
          r_d.pcfg     = pwdata[C1_PCFG_LSB +: 4];
        end
        ADDR_MASK: begin
          r_d.mask = pwdata[IRQ_DONE_BIT];
        end
        // result and status are read only here
        default: begin
        end
      endcase
    end
    // free divider while converting on the osc clock
    if (r_q.st == ADSC_CONV && !useRc && !sleepMode) begin
      r_d.divCnt = divHit ? 6'h00 : r_q.divCnt + 6'h01;
    end
    // RULE12 - successive approximation steps
    // period 0 holds the sample, 1..10 decide one bit each
    if (tadTick) begin
      r_d.tadCnt = r_q.tadCnt + 4'h1;
      r_d.hold   = 1'b0;
      if (r_q.tadCnt == SAMPLE_TAD) begin
        r_d.sar = 10'h200;
      end else if (r_q.tadCnt <= 4'ha) begin
        // compIn high means input at or above the trial
        if (!compIn) begin
          r_d.sar[bitIdx] = 1'b0;
        end
        // next lower bit becomes the new trial
        if (bitIdx != 4'h0) begin
          r_d.sar[bitIdx - 4'h1] = 1'b1;
        end
      end
      // RULE16 - twelve periods long
      if (r_q.tadCnt == LAST_TAD) begin
        // RULE14 - completion all together
        doneHit    = 1'b1;
        r_d.result = r_q.sar;
        r_d.go     = 1'b0;
        r_d.flag   = 1'b1;
        r_d.st     = ADSC_IDLE;
      end
    end
    // hold the sample in the first period only
    if (startHit) begin
      r_d.hold = 1'b1;
    end
    // RULE5 - power off aborts
    if (!r_d.pwr) begin
      r_d.st   = ADSC_IDLE;
      r_d.go   = 1'b0;
      r_d.hold = 1'b0;
    end
    // RULE8 - pin functions from code
    {r_d.pins, r_d.vpos, r_d.vneg} = pinMap(r_d.pcfg);
    // RULE19 - masked interrupt level
    r_d.irq = r_d.flag & r_d.mask;
    // RULE13 - reset everything else
    if (!reset_n) begin
      r_d          = '0;
      r_d.st       = ADSC_IDLE;
      r_d.clkSelLo = CTRL0_RST[C0_CLK_LSB +: 2];
      r_d.chanSel  = CTRL0_RST[C0_CHAN_LSB +: 3];
      r_d.pwr      = CTRL0_RST[C0_PWR_BIT];
      r_d.just     = CTRL1_RST[C1_JUST_BIT];
      r_d.clkSelHi = CTRL1_RST[C1_CLK2_BIT];
      r_d.pcfg     = CTRL1_RST[C1_PCFG_LSB +: 4];
      r_d.mask     = MASK_RST;
      // RULE10 - pins analog on reset
      r_d.pins     = PINS_RST;
      // RULE18 - result survives reset
      r_d.result   = r_q.result;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk) begin
    r_q <= r_d;
  end

  // ****************************************
  // outputs, all straight from r_q
  // ****************************************
  // RULE15 - four converter registers mapped
  assign prdata        = r_q.rdata;
  assign pready        = r_q.ready;
  assign pslverr       = r_q.err;
  assign sarTrial      = r_q.sar;
  assign sampleHold    = r_q.hold;
  // RULE5 - power to the core
  assign powerOn       = r_q.pwr;
  assign chanSel       = r_q.chanSel;
  // RULE9 - reference source outputs
  assign analogPinMask = r_q.pins;
  assign vrefPosExt    = r_q.vpos;
  assign vrefNegExt    = r_q.vneg;
  assign irq           = r_q.irq;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // RULE4 - busy reads one
  a_busy_shows_go: assert property ( // RULE4
    (r_q.st == ADSC_CONV) |-> r_q.go)
    else $error("busy without start bit");

  // RULE5 - off means idle
  a_off_is_idle: assert property ( // RULE5
    !r_q.pwr |-> (r_q.st == ADSC_IDLE && !r_q.go && !r_q.hold))
    else $error("converter active while off");

  // RULE16 - osc/2 takes 24 cycles
  a_conv_twelve: assert property ( // RULE16
    disable iff (!reset_n || sleepMode || !r_q.pwr)
    (startHit && r_d.clkSelHi == 1'b0 && r_d.clkSelLo == 2'h0)
    |-> ##24 r_q.go ##1 !r_q.go)
    else $error("conversion not twelve periods");

  // RULE14 - done sets flag
  a_done_flags: assert property ( // RULE14
    doneHit |=> (r_q.flag && !r_q.go && r_q.result == $past(r_q.sar)))
    else $error("completion effects missing");

  // RULE19 - flag holds
  a_flag_sticks: assert property ( // RULE19
    (r_q.flag && !(busDone && !pwrite && paddr == ADDR_STAT))
    |=> r_q.flag)
    else $error("flag lost without clear");

  // RULE19 - irq from flag
  a_irq_gated: assert property ( // RULE19
    r_q.irq == (r_q.flag && r_q.mask))
    else $error("irq without enabled flag");

  // RULE10 - reset pins analog
  a_reset_pins: assert property ( // RULE10
    @(posedge clk) disable iff (1'b0)
    !reset_n |=> (r_q.pins == PINS_RST && !r_q.pwr &&
                  r_q.st == ADSC_IDLE))
    else $error("reset left pins or power");

  // RULE6 - ctrl1 reserved bits 5:4 zero
  a_reserved_zero: assert property ( // RULE6
    (busAct && !r_q.ready && paddr == ADDR_CTRL1)
    |=> (r_q.rdata[5:4] == 2'h0 && r_q.ready))
    else $error("reserved control bits set");

  // RULE7 - right justify high
  a_right_justify: assert property ( // RULE7
    (busAct && !r_q.ready && paddr == ADDR_RESH && r_q.just)
    |=> r_q.rdata[7:2] == 6'h00)
    else $error("justified high byte not clear");

  // RULE11 - no progress in sleep on the osc clock
  a_sleep_stall: assert property ( // RULE11
    (sleepMode && !useRc && r_q.st == ADSC_CONV) |=> $stable(r_q.tadCnt))
    else $error("osc clock ticked in sleep");

endmodule // adsc_control

// >>> adsc_pkg.sv
// package: register map, field layout, reset values and types of the converter control
package adsc_pkg;

  // ****************************************
  // register byte addresses on the bus
  // ****************************************
  localparam logic [7:0] ADDR_RESH  = 8'h00; // result high byte
  localparam logic [7:0] ADDR_RESL  = 8'h04; // result low byte
  localparam logic [7:0] ADDR_CTRL0 = 8'h08; // adc_control_zero
  localparam logic [7:0] ADDR_CTRL1 = 8'h0c; // adc_control_one
  localparam logic [7:0] ADDR_STAT  = 8'h10; // interrupt status
  localparam logic [7:0] ADDR_MASK  = 8'h14; // interrupt mask

  // ****************************************
  // field positions
  // ****************************************
  localparam int C0_CLK_LSB  = 6; // conv_clock_select low pair, 7:6
  localparam int C0_CHAN_LSB = 3; // channel_select, 5:3
  localparam int C0_GO_BIT   = 2; // start / done
  localparam int C0_PWR_BIT  = 0; // converter_power_on
  localparam int C1_JUST_BIT = 7; // result_justify
  localparam int C1_CLK2_BIT = 6; // conv_clock_select top bit
  localparam int C1_PCFG_LSB = 0; // port_config_code, 3:0
  localparam int IRQ_DONE_BIT = 0; // conversion_complete_flag

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic       MASK_RST  = 1'b0;
  localparam logic [7:0] PINS_RST  = 8'hff; // every shared pin analog

  // ****************************************
  // timing, in conv_bit_period units
  // ****************************************
  localparam logic [3:0] CONV_TADS = 4'hc; // periods per conversion
  localparam logic [3:0] LAST_TAD  = CONV_TADS - 4'h1;
  localparam logic [3:0] SAMPLE_TAD = 4'h0; // hold period

  // sequencer states
  typedef enum logic {ADSC_IDLE, ADSC_CONV} adsc_state_t;

  // whole state of the block
  typedef struct packed {
    logic [1:0]  clkSelLo;
    logic [2:0]  chanSel;
    logic        go;
    logic        pwr;
    logic        just;
    logic        clkSelHi;
    logic [3:0]  pcfg;
    logic [9:0]  result;
    logic        flag;
    logic        mask;
    adsc_state_t st;
    logic [5:0]  divCnt;
    logic [3:0]  tadCnt;
    logic [9:0]  sar;
    logic        hold;
    logic [7:0]  pins;
    logic        vpos;
    logic        vneg;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        irq;
  } adsc_regs_t;

endpackage

// >>> adsc_core_model.sv
// behavioural conversion core that faces the converter control
`timescale 1ns/1ps

module adsc_core_model (
  input  wire logic        clk,
  input  wire logic [79:0] levels,
  input  wire logic        powerOn,
  input  wire logic [2:0]  chanSel,
  input  wire logic [9:0]  sarTrial,
  input  wire logic        sampleHold,
  output logic             compIn
);
  logic [9:0] heldQ;        // sample and hold output
  logic       junkQ = 1'b0; // noise while unpowered
  // ****************************************
  // sample, hold and compare
  // ****************************************
  // hold tracks the routed input
  always_ff @(posedge clk) begin
    junkQ <= ~junkQ;
    if (sampleHold) begin
      heldQ <= levels[chanSel*10 +: 10];
    end
  end
  // an unpowered core gives no usable answer, so it toggles
  assign compIn = powerOn ? (heldQ >= sarTrial) : junkQ;
endmodule // adsc_core_model

// >>> adsc_control_tb.sv
// self-checking bench of the converter control
`timescale 1ns/1ps

module adsc_control_tb
  import adsc_pkg::*;
;
  logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, rcTick = 1'b0, sleepMode = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [79:0] levels = '0;
  logic [2:0]  rcCnt = 3'h0;           // rc tick every seven cycles
  logic [31:0] prdata;
  logic        pready, pslverr, compIn, sampleHold, powerOn, vpos, vneg, irq;
  logic [9:0]  sarTrial, lastV;
  logic [2:0]  chanSel;
  logic [7:0]  pinMask;
  logic [32:0] expQ[$];                // expected {error, read data}
  int          miscompares = 0, samples_checked = 0, cycles = 0;
  // analog pin map and reference choice per port code
  localparam logic [7:0] PIN_TAB [16] = '{8'hff, 8'hff, 8'h1f, 8'h1f, 8'h0b, 8'h0b,
    8'h00, 8'h00, 8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h1f, 8'h0f, 8'h01, 8'h0d};
  localparam logic [15:0] VPOS_TAB = 16'hbd2a;
  localparam logic [15:0] VNEG_TAB = 16'hb900;

  adsc_control DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rcTick(rcTick), .sleepMode(sleepMode), .compIn(compIn),
    .sarTrial(sarTrial), .sampleHold(sampleHold), .powerOn(powerOn), .chanSel(chanSel),
    .analogPinMask(pinMask), .vrefPosExt(vpos), .vrefNegExt(vneg), .irq(irq));
  adsc_core_model core (.clk(clk), .levels(levels), .powerOn(powerOn), .chanSel(chanSel),
    .sarTrial(sarTrial), .sampleHold(sampleHold), .compIn(compIn));

  // ****************************************
  // clock, rc ticks, timeout, monitor
  // ****************************************
  initial begin
    forever #4 clk = ~clk;
  end
  // rc tick unrelated to the divider phase
  always @(posedge clk) begin
    rcCnt <= (rcCnt == 3'h6) ? 3'h0 : rcCnt + 3'h1;
    rcTick <= (rcCnt == 3'h0);
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      close_out();
    end
  end
  // oldest note is compared when read data comes back
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      check({pslverr, prdata}, expQ.pop_front());
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] adr, input logic [32:0] val);
    if (!wr) expQ.push_back(val);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= val[31:0];
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input int cyc);
    reset_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    reset_n <= 1'b1;
  endtask
  task automatic reset_checks;
    apb(1'b0, ADDR_CTRL0, 33'h0);
    apb(1'b0, ADDR_CTRL1, 33'h0);
    apb(1'b0, ADDR_MASK, 33'h0);
    apb(1'b0, ADDR_STAT, 33'h0);
    check(33'({pinMask, vpos, vneg, irq, powerOn}), 33'hff0);
  endtask
  // one conversion at clock code cs, irq unmasked
  task automatic convert(input logic [2:0] cs, input logic just);
    logic [2:0] ch;
    logic [9:0] v;
    int         n;
    int         div;
    ch = 3'($urandom_range(7)); // only implemented channels
    v = 10'($urandom());
    n = 0;
    div = (cs[1:0] == 2'b11) ? 7 : 1 << (1 + cs[2] + 2 * cs[1:0]);
    levels[ch*10 +: 10] <= v;
    apb(1'b1, ADDR_CTRL1, {25'h0, just, cs[2], 6'h00});
    // sleep only while the rc clock is chosen
    sleepMode <= (cs[1:0] == 2'b11);
    repeat (2 * div) @(posedge clk);
    apb(1'b1, ADDR_CTRL0, {25'h0, cs[1:0], ch, 3'b101});
    fork
      apb(1'b0, ADDR_CTRL0, {25'h0, cs[1:0], ch, 3'b101});
      do begin @(posedge clk); n++; end while (irq !== 1'b1);
    join
    // rc tick phase is free, so only divider codes have a fixed length
    if (cs[1:0] != 2'b11) check(33'(n), 33'(12 * div + 1));
    check(33'({powerOn, chanSel}), 33'({1'b1, ch}));
    sleepMode <= 1'b0;
    apb(1'b0, ADDR_CTRL0, {25'h0, cs[1:0], ch, 3'b001});
    apb(1'b0, ADDR_RESH, just ? 33'(v[9:8]) : 33'(v[9:2]));
    apb(1'b0, ADDR_RESL, just ? 33'(v[7:0]) : 33'({v[1:0], 6'h00}));
    apb(1'b0, ADDR_STAT, 33'h1);
    settle();
    check(33'(irq), 33'h0);
    lastV = v;
  endtask
  task automatic close_out;
    $display("compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hf4f2));
    do_reset(16);
    reset_checks();
    apb(1'b0, 8'h18, {1'b1, 32'h0});
    apb(1'b1, ADDR_CTRL0, 33'hfb);
    apb(1'b0, ADDR_CTRL0, 33'hf9);
    check(33'({powerOn, chanSel}), 33'h0f);
    apb(1'b1, ADDR_CTRL1, 33'hff);
    apb(1'b0, ADDR_CTRL1, 33'hcf);
    apb(1'b1, ADDR_CTRL0, 33'h04);
    apb(1'b0, ADDR_CTRL0, 33'h00);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, ADDR_CTRL1, 33'(i));
      settle();
      check(33'({pinMask, vpos, vneg}), 33'({PIN_TAB[i], VPOS_TAB[i], VNEG_TAB[i]}));
    end
    // masked completion, then mask toggled and status read
    apb(1'b1, ADDR_CTRL1, 33'h00);
    apb(1'b1, ADDR_CTRL0, 33'h05);
    repeat (40) @(posedge clk);
    check(33'(irq), 33'h0);
    apb(1'b1, ADDR_MASK, 33'h1);
    settle();
    check(33'(irq), 33'h1);
    apb(1'b1, ADDR_MASK, 33'h0);
    settle();
    check(33'(irq), 33'h0);
    apb(1'b1, ADDR_MASK, 33'h1);
    apb(1'b0, ADDR_STAT, 33'h1);
    // justify alternates so both layouts are read back
    for (int c = 0; c < 8; c++) convert(3'(c), 1'(c));
    // divider clock stalls in sleep, power off then aborts
    @(posedge clk);
    sleepMode <= 1'b1;
    apb(1'b1, ADDR_CTRL0, 33'h05);
    repeat (60) @(posedge clk);
    check(33'(irq), 33'h0);
    apb(1'b1, ADDR_CTRL0, 33'h00);
    sleepMode <= 1'b0;
    // longer than the 48 cycles an unaborted osc/4 run would need
    repeat (60) @(posedge clk);
    check(33'({irq, powerOn}), 33'h0);
    apb(1'b0, ADDR_CTRL0, 33'h00);
    // reset in mid conversion keeps the result
    apb(1'b1, ADDR_CTRL1, 33'h40);
    apb(1'b1, ADDR_CTRL0, 33'h85);
    repeat (100) @(posedge clk);
    do_reset(2);
    reset_checks();
    apb(1'b0, ADDR_RESH, 33'(lastV[9:2]));
    apb(1'b0, ADDR_RESL, 33'({lastV[1:0], 6'h00}));
    close_out();
  end
endmodule // adsc_control_tb
